// [src/udt_timer.v]
`timescale 1ns/1ps
`include "udt_defines.vh"
// Contract
// - external dma moves one byte per request
// - one internal/external select bit per channel
// - external compare channel only outputs to port
// - compare request on match or software flag
// - sync strobe while output byte on bus
// - optional single on-chip event pulse on compare
// - capture channel direction follows port direction bit
// - capture request on input a or flag
// - extra sync signal for capture transfers
// - toggled output zero can chain capture requests
// - nine registers, absent instance reserved
// - capture/load 0 captures or presets counter
// - two 16-bit compare registers
// - run bit anded with global enable
// - clear on capture clears counter
// - clear on compare0 clears counter
// - writing one clears counter, no interrupt
// - software direction bit when pins silent
// - direction status reads actual direction
// - flag wrap coinciding with capture zero
// - running status bit
module udt_timer #(
    parameter PRESENT = 1
) (
    // clock and reset
    input  wire       clk,
    input  wire       nrst,
    // register file access
    input  wire [7:0] regAddr,
    input  wire       regWr,
    input  wire       regRd,
    input  wire [7:0] regWrData,
    output reg  [7:0] regRdData,
    // global enable and companion settings
    input  wire       global_counter_enable,
    input  wire       capture_chan_external_sel,
    input  wire       compare_chan_external_sel,
    input  wire       port_dma_direction,
    input  wire       onChipEventEn,
    input  wire       compareToggle,
    input  wire       captureBothEdges,
    input  wire       inputFromOutput,
    input  wire       captureLoadMode,
    input  wire       dirFromPins,
    input  wire       pinDirUp,
    // pins and events
    input  wire       timer_input_a,
    input  wire       compareFlagWr,
    input  wire       captureFlagWr,
    // memory byte stream to port
    input  wire       memByteValid,
    input  wire [7:0] memByte,
    output wire       memByteReady,
    // port side
    output reg        compareDmaReq,
    output reg        captureDmaReq,
    output reg        compareSync,
    output reg        captureSync,
    output reg        captureToPort,
    output reg        onChipEvent,
    output reg  [7:0] portByte,
    output reg        timerOut0
);
    reg  [15:0] counter;
    reg  [15:0] capLoad0;
    reg  [15:0] capLoad1;
    reg  [15:0] compare0;
    reg  [15:0] compare1;
    reg         counter_run_enable;
    reg         clear_on_capture;
    reg         clear_on_compare;
    reg         sw_count_direction;
    reg         wrap_during_capture_flag;
    reg         inA1;
    reg         inA2;
    reg         inA3;
    reg         pinUp1;
    reg         pinUp2;
    wire        running;
    wire        countUp;
    wire        edgeA;
    wire        capEvent;
    wire        compare_zero_match;
    wire        wrapNow;
    wire        fifoValid;
    wire [7:0]  fifoData;
    wire        fifoTake;
    wire        hit;

    function [7:0] pick;
        input [15:0] v;
        input        low;
        begin
            pick = low ? v[7:0] : v[15:8];
        end
    endfunction

    assign hit     = (PRESENT != 0);
    assign running = counter_run_enable & global_counter_enable;
    assign countUp = dirFromPins ? pinUp2 : sw_count_direction;
    // capture edge on input a, or output zero when chained
    assign edgeA = inputFromOutput ? 1'b0 : (captureBothEdges ? (inA2 ^ inA3) : (inA2 & ~inA3));
    assign compare_zero_match = running & (counter == compare0);
    assign capEvent = edgeA | (inputFromOutput & captureBothEdges & compare_zero_match & compareToggle);
    assign wrapNow = running & (countUp ? (counter == 16'hFFFF) : (counter == 16'h0000));
    // compare channel takes one byte per request
    assign fifoTake = compare_chan_external_sel & (compare_zero_match | compareFlagWr);

    udt_fifo #(
        .WIDTH (8),
        .DEPTH (`UDT_FIFO_DEPTH),
        .AW    (`UDT_FIFO_AW)
    ) byteQueue (
        .clk      (clk),
        .nrst     (nrst),
        .inValid  (memByteValid),
        .inReady  (memByteReady),
        .inData   (memByte),
        .outValid (fifoValid),
        .outReady (fifoTake),
        .outData  (fifoData)
    );

    // pin synchronisers
    always @(posedge clk) begin
        if (!nrst) begin
            inA1   <= 1'b0;
            inA2   <= 1'b0;
            inA3   <= 1'b0;
            pinUp1 <= 1'b0;
            pinUp2 <= 1'b0;
        end else begin
            inA1   <= timer_input_a;
            inA2   <= inA1;
            inA3   <= inA2;
            pinUp1 <= pinDirUp;
            pinUp2 <= pinUp1;
        end
    end

    // counter and control
    always @(posedge clk) begin
        if (!nrst) begin
            counter                  <= 16'h0000;
            counter_run_enable       <= 1'b0;
            clear_on_capture         <= 1'b0;
            clear_on_compare         <= 1'b0;
            sw_count_direction       <= 1'b0;
            wrap_during_capture_flag <= 1'b0;
        end else begin
            if (regWr && hit && regAddr == `UDT_CTRL_STATUS) begin
                counter_run_enable <= regWrData[`UDT_BIT_RUN];
                clear_on_capture   <= regWrData[`UDT_BIT_CLRCAP];
                clear_on_compare   <= regWrData[`UDT_BIT_CLRCMP];
                sw_count_direction <= regWrData[`UDT_BIT_SWDIR];
            end
            if (capEvent && captureLoadMode) begin
                wrap_during_capture_flag <= wrapNow;
            end
            if (regWr && hit && regAddr == `UDT_CTRL_STATUS && regWrData[`UDT_BIT_CLEAR]) begin
                counter <= 16'h0000;
            end else if (capEvent && captureLoadMode && clear_on_capture) begin
                counter <= 16'h0000;
            end else if (compare_zero_match && clear_on_compare) begin
                counter <= 16'h0000;
            end else if (capEvent && !captureLoadMode) begin
                counter <= capLoad0;
            end else if (running) begin
                counter <= countUp ? counter + 16'h0001 : counter - 16'h0001;
            end
        end
    end

    // data registers, no reset content
    always @(posedge clk) begin
        if (capEvent && captureLoadMode) begin
            capLoad0 <= counter;
        end else if (regWr && hit && regAddr == `UDT_CAPLOAD0_HIGH) begin
            capLoad0[15:8] <= regWrData;
        end else if (regWr && hit && regAddr == `UDT_CAPLOAD0_LOW) begin
            capLoad0[7:0] <= regWrData;
        end
        if (regWr && hit && regAddr == `UDT_CAPLOAD1_HIGH) begin
            capLoad1[15:8] <= regWrData;
        end
        if (regWr && hit && regAddr == `UDT_CAPLOAD1_LOW) begin
            capLoad1[7:0] <= regWrData;
        end
        if (regWr && hit && regAddr == `UDT_COMPARE0_HIGH) begin
            compare0[15:8] <= regWrData;
        end
        if (regWr && hit && regAddr == `UDT_COMPARE0_LOW) begin
            compare0[7:0] <= regWrData;
        end
        if (regWr && hit && regAddr == `UDT_COMPARE1_HIGH) begin
            compare1[15:8] <= regWrData;
        end
        if (regWr && hit && regAddr == `UDT_COMPARE1_LOW) begin
            compare1[7:0] <= regWrData;
        end
    end

    // read port
    always @(posedge clk) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else if (regRd && hit) begin
            case (regAddr)
                `UDT_CAPLOAD0_HIGH: regRdData <= pick(capLoad0, 1'b0);
                `UDT_CAPLOAD0_LOW:  regRdData <= pick(capLoad0, 1'b1);
                `UDT_CAPLOAD1_HIGH: regRdData <= pick(capLoad1, 1'b0);
                `UDT_CAPLOAD1_LOW:  regRdData <= pick(capLoad1, 1'b1);
                `UDT_COMPARE0_HIGH: regRdData <= pick(compare0, 1'b0);
                `UDT_COMPARE0_LOW:  regRdData <= pick(compare0, 1'b1);
                `UDT_COMPARE1_HIGH: regRdData <= pick(compare1, 1'b0);
                `UDT_COMPARE1_LOW:  regRdData <= pick(compare1, 1'b1);
                `UDT_CTRL_STATUS:   regRdData <= {counter_run_enable, clear_on_capture, clear_on_compare, 1'b0,
                                                  sw_count_direction, countUp, wrap_during_capture_flag,
                                                  running};
                default:            regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // dma requests and port strobes
    always @(posedge clk) begin
        if (!nrst) begin
            compareDmaReq <= 1'b0;
            captureDmaReq <= 1'b0;
            compareSync   <= 1'b0;
            captureSync   <= 1'b0;
            captureToPort <= 1'b0;
            onChipEvent   <= 1'b0;
            portByte      <= 8'h00;
            timerOut0     <= 1'b0;
        end else begin
            compareDmaReq <= fifoTake;
            compareSync   <= fifoTake & fifoValid;
            if (fifoTake && fifoValid) begin
                portByte <= fifoData;
            end
            onChipEvent   <= onChipEventEn & compare_zero_match;
            captureDmaReq <= capture_chan_external_sel & (capEvent | captureFlagWr);
            captureSync   <= capture_chan_external_sel & (capEvent | captureFlagWr);
            captureToPort <= port_dma_direction;
            if (compare_zero_match && compareToggle) begin
                timerOut0 <= ~timerOut0;
            end
        end
    end
endmodule // udt_timer

// [src/udt_defines.vh]
`ifndef UDT_DEFINES_VH
`define UDT_DEFINES_VH
// register offsets in the register file
`define UDT_CAPLOAD0_HIGH 8'hF0
`define UDT_CAPLOAD0_LOW  8'hF1
`define UDT_CAPLOAD1_HIGH 8'hF2
`define UDT_CAPLOAD1_LOW  8'hF3
`define UDT_COMPARE0_HIGH 8'hF4
`define UDT_COMPARE0_LOW  8'hF5
`define UDT_COMPARE1_HIGH 8'hF6
`define UDT_COMPARE1_LOW  8'hF7
`define UDT_CTRL_STATUS   8'hF8
// counter control status fields
`define UDT_BIT_RUN       7
`define UDT_BIT_CLRCAP    6
`define UDT_BIT_CLRCMP    5
`define UDT_BIT_CLEAR     4
`define UDT_BIT_SWDIR     3
`define UDT_BIT_DIRSTAT   2
`define UDT_BIT_WRAPCAP   1
`define UDT_BIT_RUNSTAT   0
`define UDT_CTRL_RESET    4'h0
// fifo
`define UDT_FIFO_DEPTH    16
`define UDT_FIFO_AW       4
`endif

// [src/udt_fifo.v]
`timescale 1ns/1ps
module udt_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             nrst,
    // fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            doWr;
    wire            doRd;

    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;

    always @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
        if (!nrst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWr && !doRd) begin
                count <= count + 1'b1;
            end else if (doRd && !doWr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // udt_fifo

// [testbench/udt_timer_chk.sv]
`timescale 1ns/1ps
module udt_timer_chk (
    // clock and reset
    input wire       clk, nrst,
    // register file
    input wire       regRd,
    input wire [7:0] regAddr, regRdData,
    // channel controls
    input wire       compare_chan_external_sel, capture_chan_external_sel, port_dma_direction,
    input wire       onChipEventEn, compareFlagWr, captureFlagWr,
    // port side
    input wire       compareDmaReq, captureDmaReq, compareSync, captureSync, captureToPort, onChipEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rd_idle; !$past(regRd) |-> regRdData == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; regRd && (regAddr > 8'hF8 || regAddr < 8'hF0) |=> regRdData == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_req_single; compareDmaReq |=> !compareDmaReq; endproperty
    a_req_single: assert property (p_req_single) else $error("compare request too long");
    property p_sync_req; compareSync |-> compareDmaReq && $past(compare_chan_external_sel); endproperty
    a_sync_req: assert property (p_sync_req) else $error("sync without external request");
    property p_flag_cmp; compareFlagWr && compare_chan_external_sel |=> compareDmaReq; endproperty
    a_flag_cmp: assert property (p_flag_cmp) else $error("compare flag gave no request");
    property p_flag_cap; captureFlagWr && capture_chan_external_sel |=> captureDmaReq; endproperty
    a_flag_cap: assert property (p_flag_cap) else $error("capture flag gave no request");
    property p_dir; captureToPort == $past(port_dma_direction); endproperty
    a_dir: assert property (p_dir) else $error("port direction not followed");
    property p_event; onChipEvent |-> compareDmaReq && $past(onChipEventEn); endproperty
    a_event: assert property (p_event) else $error("stray on chip event");
    property p_cap_sync; captureSync |-> captureDmaReq || $past(captureDmaReq); endproperty
    a_cap_sync: assert property (p_cap_sync) else $error("capture sync without request");
    c_sync: cover property (compareSync);
    c_event: cover property (onChipEvent);
    c_cap: cover property (captureDmaReq);
endmodule // udt_timer_chk
bind udt_timer udt_timer_chk udt_timer_chk_inst (.clk, .nrst, .regRd, .regAddr, .regRdData,
    .compare_chan_external_sel, .capture_chan_external_sel, .port_dma_direction, .onChipEventEn,
    .compareFlagWr, .captureFlagWr, .compareDmaReq, .captureDmaReq, .compareSync, .captureSync,
    .captureToPort, .onChipEvent);

// [testbench/udt_port_model.sv]
`timescale 1ns/1ps
module udt_port_model (
    // clock and reset
    input  wire       clk,
    input  wire       nrst,
    // timer side
    input  wire       compareSync,
    input  wire       captureSync,
    input  wire [7:0] portByte,
    // latched port state
    output reg  [7:0] portLatch,
    output reg  [7:0] syncCount
);
    always @(posedge clk) begin
        if (!nrst) begin
            portLatch <= 8'h00;
            syncCount <= 8'h00;
        end else begin
            if (compareSync) portLatch <= portByte;
            if (captureSync) syncCount <= syncCount + 8'h01;
        end
    end
endmodule // udt_port_model

// [testbench/udt_timer_tb_top.sv]
`timescale 1ns/1ps
module udt_timer_tb_top;
    reg        clk = 0, nrst = 0, regWr = 0, regRd = 0, memByteValid = 0, rdSeen = 0;
    reg  [7:0] regAddr = 8'h00, regWrData = 8'h00, memByte = 8'h00;
    reg        global_counter_enable = 1, capture_chan_external_sel = 0, compare_chan_external_sel = 0;
    reg        port_dma_direction = 0, onChipEventEn = 1, compareToggle = 0;
    reg        timer_input_a = 0, compareFlagWr = 0, captureFlagWr = 0, pinDirUp = 0;
    wire [7:0] regRdData, portByte, portLatch, syncCount;
    wire       memByteReady, compareDmaReq, captureDmaReq, compareSync, captureSync, captureToPort;
    wire       onChipEvent, timerOut0;
    integer    miscompares = 0, checked = 0, i, k;
    reg [31:0] seed = 32'd60416;
    reg [15:0] cv, e;
    reg [15:0] rdQ[$];
    reg [7:0]  byteQ[$];
    udt_timer udt_timer_inst (.clk, .nrst, .regAddr, .regWr, .regRd, .regWrData, .regRdData,
        .global_counter_enable, .capture_chan_external_sel, .compare_chan_external_sel, .port_dma_direction,
        .onChipEventEn, .compareToggle, .captureBothEdges(1'b1), .inputFromOutput(1'b0),
        .captureLoadMode(1'b1), .dirFromPins(1'b0), .pinDirUp, .timer_input_a, .compareFlagWr,
        .captureFlagWr, .memByteValid, .memByte, .memByteReady, .compareDmaReq, .captureDmaReq,
        .compareSync, .captureSync, .captureToPort, .onChipEvent, .portByte, .timerOut0);
    udt_port_model udt_port_model_inst (.clk, .nrst, .compareSync, .captureSync, .portByte, .portLatch,
        .syncCount);
    initial begin
        forever #20 clk = ~clk;
    end
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task chk(input ok, input string msg);
        checked = checked + 1;
        if (ok !== 1'b1) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [7:0] m, input [7:0] x);
        rdQ.push_back({m, x});
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
    endtask
    // push bytes until lim taken or 24 cycles have passed in total
    task fill(input integer lim);
        integer t;
        t = 0;
        k = 0;
        @(posedge clk);
        seed = xs(seed);
        memByte <= seed[7:0];
        memByteValid <= 1'b1;
        while (k < lim && t < 24) begin
            @(negedge clk);
            t = t + 1;
            if (memByteReady === 1'b1) begin
                byteQ.push_back(memByte);
                k = k + 1;
                @(posedge clk);
                seed = xs(seed);
                memByte <= seed[7:0];
                memByteValid <= (k < lim);
            end
        end
        @(posedge clk);
        memByteValid <= 1'b0;
    endtask
    task flag(input w);
        @(posedge clk);
        if (w) captureFlagWr <= 1'b1;
        else compareFlagWr <= 1'b1;
        @(posedge clk);
        captureFlagWr <= 1'b0;
        compareFlagWr <= 1'b0;
    endtask
    task waitp(input w, input integer lim);
        integer n;
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while ((w ? captureDmaReq : compareDmaReq) !== 1'b1 && n < lim);
        chk((w ? captureDmaReq : compareDmaReq) === 1'b1, "no dma request");
    endtask
    always @(posedge clk) rdSeen <= regRd;
    always @(negedge clk) begin
        if (rdSeen) begin
            e = rdQ.pop_front();
            chk((regRdData & e[15:8]) === e[7:0], "read data");
        end
        if (compareSync === 1'b1) begin
            chk(byteQ.size() != 0 && portByte === byteQ[0], "port byte");
            if (byteQ.size() != 0) byteQ.delete(0);
        end
    end
    task end_of_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // the whole sequence needs well under a thousand cycles
    initial begin
        #(40 * 5000);
        miscompares = miscompares + 1;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(8'hF8, 8'hFF, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            wr(8'hF0 + i, seed[7:0]);
            rd(8'hF0 + i, 8'hFF, seed[7:0]);
        end
        wr(8'hF9, 8'h5A);
        rd(8'hF9, 8'hFF, 8'h00);
        $display("test registers done");
        fill(20);
        chk(k == 16 && memByteReady === 1'b0, "fifo not full");
        compare_chan_external_sel <= 1'b1;
        for (i = 0; i < 16; i = i + 1) begin
            flag(1'b0);
            waitp(1'b0, 3);
            seed = xs(seed);
            repeat (seed[1:0]) @(posedge clk);
        end
        @(negedge clk);
        chk(byteQ.size() == 0 && memByteReady === 1'b1, "fifo not drained");
        $display("test fifo drain done");
        compareToggle <= 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            cv = i ? 16'hFFF0 : 16'h0010;
            wr(8'hF4, cv[15:8]);
            wr(8'hF5, cv[7:0]);
            fill(1);
            wr(8'hF8, i ? 8'h90 : 8'h98);
            rd(8'hF8, 8'h05, i ? 8'h01 : 8'h05);
            waitp(1'b0, 40);
            @(negedge clk);
            chk(timerOut0 === (i == 0) && portLatch === portByte, "compare output");
            wr(8'hF8, 8'h00);
        end
        compareToggle <= 1'b0;
        $display("test compare match done");
        capture_chan_external_sel <= 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            port_dma_direction <= i[0];
            seed = xs(seed);
            pinDirUp <= seed[0];
            flag(1'b1);
            waitp(1'b1, 3);
            @(posedge clk);
            timer_input_a <= ~timer_input_a;
            waitp(1'b1, 8);
            chk(captureToPort === i[0], "capture direction");
        end
        chk(syncCount !== 8'h00, "no capture sync");
        $display("test capture done");
        end_of_test;
    end
endmodule // udt_timer_tb_top
